// *** interval_timer.sv ***
// Interval counter that stays alive between periodic measurements.
// Assumes run and restart come from registers of the sequencer.
module interval_timer #(
  parameter int unsigned PERIOD1 = mag_seq_pkg::INTERVAL1_CYC,
  parameter int unsigned PERIOD2 = mag_seq_pkg::INTERVAL2_CYC,
  parameter int unsigned PERIOD3 = mag_seq_pkg::INTERVAL3_CYC,
  parameter int unsigned PERIOD4 = mag_seq_pkg::INTERVAL4_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [1:0] rate,
  output logic            tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tmr_t;

  tmr_t        s_q;
  tmr_t        s_d;
  logic [31:0] last;

  always_comb
  begin
    unique case (rate)
      2'h0: last = 32'(PERIOD1 - 1);
      2'h1: last = 32'(PERIOD2 - 1);
      2'h2: last = 32'(PERIOD3 - 1);
      2'h3: last = 32'(PERIOD4 - 1);
    endcase
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run || restart)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt >= last)
    begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule

// *** mag_host_model.sv ***
// Host controller model: AHB-Lite master issuing single word transfers.
// Assumes one zero-wait slave whose HREADYOUT comes back as hready.
module mag_host_model #(
  parameter int unsigned WAIT_CYC = 25000
) (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial
  begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'h1;
    htrans <= mag_seq_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    // Unused write data is scrambled so a stale word cannot pass as valid
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'h0, a, 32'h0, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    xfer(1'h1, a, v, d);
  endtask

  // Mode changes always pass through power-down and its settling wait
  task automatic set_mode(input logic [4:0] m);
    wr(mag_seq_pkg::OFS_MODE_CONTROL, 32'h0);
    repeat (WAIT_CYC) @(posedge clk);
    wr(mag_seq_pkg::OFS_MODE_CONTROL, {27'h0, m});
  endtask
endmodule

// *** mag_seq_pkg.sv ***
// Constants, types and helpers shared by the mode sequencer and its interval timer.
// Assumes a single 250 MHz clock and word-aligned AHB-Lite register access.
package mag_seq_pkg;

  localparam int unsigned CLK_HZ   = 250_000_000;
  localparam int unsigned RATE1_HZ = 10;
  localparam int unsigned RATE2_HZ = 20;
  localparam int unsigned RATE3_HZ = 50;
  localparam int unsigned RATE4_HZ = 100;
  localparam int unsigned INTERVAL1_CYC = CLK_HZ / RATE1_HZ;
  localparam int unsigned INTERVAL2_CYC = CLK_HZ / RATE2_HZ;
  localparam int unsigned INTERVAL3_CYC = CLK_HZ / RATE3_HZ;
  localparam int unsigned INTERVAL4_CYC = CLK_HZ / RATE4_HZ;
  localparam int unsigned MEAS_CYC_DEFAULT = 2000;

  localparam int unsigned MODE_W = 5;
  localparam int unsigned ADDR_W = 8;
  localparam logic [4:0] MODE_POWER_DOWN = 5'h00;
  localparam logic [4:0] MODE_SINGLE     = 5'h01;
  localparam logic [4:0] MODE_PERIODIC1  = 5'h02;
  localparam logic [4:0] MODE_PERIODIC2  = 5'h04;
  localparam logic [4:0] MODE_PERIODIC3  = 5'h06;
  localparam logic [4:0] MODE_PERIODIC4  = 5'h08;

  localparam logic [7:0] OFS_FIRST_STATUS  = 8'h00;
  localparam logic [7:0] OFS_X_RESULT      = 8'h04;
  localparam logic [7:0] OFS_Y_RESULT      = 8'h08;
  localparam logic [7:0] OFS_Z_RESULT      = 8'h0C;
  localparam logic [7:0] OFS_TEMP_RESULT   = 8'h10;
  localparam logic [7:0] OFS_SECOND_STATUS = 8'h14;
  localparam logic [7:0] OFS_MODE_CONTROL  = 8'h18;
  localparam logic [7:0] OFS_CONTROL       = 8'h1C;
  localparam logic [7:0] OFS_SENS_ADJUST   = 8'h20;

  localparam int unsigned BIT_DATA_READY  = 0;
  localparam int unsigned BIT_DATA_OVERRUN = 1;
  localparam int unsigned BIT_OVERFLOW    = 0;
  localparam int unsigned BIT_TEMP_ENABLE = 0;
  localparam int unsigned BIT_SOFT_RESET  = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       RST_HREADYOUT = 1'b1;

  typedef enum logic [1:0] {ST_POWER_DOWN, ST_MEASURE, ST_IDLE} seq_state_t;

  function automatic logic is_periodic(input logic [4:0] m);
    return (m == MODE_PERIODIC1) || (m == MODE_PERIODIC2) ||
           (m == MODE_PERIODIC3) || (m == MODE_PERIODIC4);
  endfunction

  function automatic logic [1:0] rate_index(input logic [4:0] m);
    return m[2:1] - 2'h1;
  endfunction

endpackage

// *** magnetometer_mode_sequencer.sv ***
// Operating-mode sequencer, data-ready and status logic of a 3-axis magnetic sensor.
// Assumes an AHB-Lite master on a 250 MHz clock and sensor results valid at measurement end.
// Notes on behaviour
// - Power-on reset initialises all registers and leaves the device powered down.
// - Interface supply off holds the device in reset while it stays off.
// - External active-low reset pin resets like any other source.
// - Any reset clears all but sensitivity adjust values, enters power-down.
// - Mode 00001 measures once, stores results, returns to power-down, mode 00000.
// - Modes 00010, 00100, 00110, 01000 measure periodically at 10/20/50/100 Hz.
// - Stored readable results set data-ready; periodically on entering idle.
// - Reading any result register or second status clears data-ready.
// - Data-ready stays set when leaving power-down for another mode.
// - Data-ready pin always equals the data-ready status bit.
// - Results hold previous values during measurement; reads return old data.
// - Periodic idle keeps only interval counter, wakes and measures again.
// - Periodic measurement repeats until power-down is written.
// - Rewriting a periodic mode restarts without clearing data-ready, overrun or results; overflow clears.
// - Temperature enable captures temperature with each magnetic measurement.
// - Start of a read sequence clears data-ready and data-overrun.
// - Results are frozen from read start until second status is read.
// - Overflow bit reads 1 after an overflowed measurement, else 0.
// - Unread results at next completion keep data-ready and set overrun.
// - Open read sequence at completion discards new results, sets overrun.
// - In power-down all registers are accessible and keep their contents.
// - Overflow bit returns to 0 when the next measurement starts.
module magnetometer_mode_sequencer #(
  parameter int unsigned PERIOD1     = mag_seq_pkg::INTERVAL1_CYC,
  parameter int unsigned PERIOD2     = mag_seq_pkg::INTERVAL2_CYC,
  parameter int unsigned PERIOD3     = mag_seq_pkg::INTERVAL3_CYC,
  parameter int unsigned PERIOD4     = mag_seq_pkg::INTERVAL4_CYC,
  parameter int unsigned MEAS_CYCLES = mag_seq_pkg::MEAS_CYC_DEFAULT
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        SUPPLY_OFF,
  input  wire logic        EXTERNAL_RESET_N,
  input  wire logic [15:0] SENSOR_X,
  input  wire logic [15:0] SENSOR_Y,
  input  wire logic [15:0] SENSOR_Z,
  input  wire logic [7:0]  SENSOR_TEMP,
  input  wire logic        SENSOR_OVERFLOW,
  input  wire logic [7:0]  X_SENSITIVITY_ADJUST,
  input  wire logic [7:0]  Y_SENSITIVITY_ADJUST,
  input  wire logic [7:0]  Z_SENSITIVITY_ADJUST,
  output logic             DATA_READY,
  output logic             ANALOG_ENABLE,
  output logic             TEMP_ENABLE_OUT
);

  typedef struct packed {
    mag_seq_pkg::seq_state_t fsm;
    logic [4:0]              mode;
    logic                    temp_en;
    logic                    temp_active;
    logic                    rdy_flag;
    logic                    ovr_flag;
    logic                    ofl;
    logic                    read_open;
    logic [15:0]             x;
    logic [15:0]             y;
    logic [15:0]             z;
    logic [7:0]              temp;
    logic [23:0]             sens;
    logic                    sens_loaded;
    logic [31:0]             meas_cnt;
    logic                    analog_on;
    logic                    restart;
    logic                    wr_pend;
    logic [7:0]              wr_addr;
    logic [31:0]             rdata;
    logic                    hreadyout;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  state_t      keep;
  logic        tick;
  logic        rd_fire;
  logic        wr_fire;
  logic [7:0]  addr;
  logic        rd_result;
  logic        rd_stat2;
  logic        mode_wr;
  logic        ctl_wr;
  logic [4:0]  new_mode;
  logic        sync_rst;
  logic        meas_done;
  logic        meas_start;
  logic        store;
  logic [31:0] rmux;

  interval_timer #(
    .PERIOD1 (PERIOD1),
    .PERIOD2 (PERIOD2),
    .PERIOD3 (PERIOD3),
    .PERIOD4 (PERIOD4)
  ) u_timer (
    .clk     (CLK),
    .rst_b   (RST_B),
    .run     ((s_q.fsm != mag_seq_pkg::ST_POWER_DOWN) && mag_seq_pkg::is_periodic(s_q.mode)),
    .restart (s_q.restart),
    .rate    (mag_seq_pkg::rate_index(s_q.mode)),
    .tick    (tick)
  );

  always_comb
  begin
    rmux = '0;
    unique case (addr)
      mag_seq_pkg::OFS_FIRST_STATUS:
      begin
        rmux[mag_seq_pkg::BIT_DATA_READY]   = s_q.rdy_flag;
        rmux[mag_seq_pkg::BIT_DATA_OVERRUN] = s_q.ovr_flag;
      end
      mag_seq_pkg::OFS_X_RESULT:      rmux[15:0] = s_q.x;
      mag_seq_pkg::OFS_Y_RESULT:      rmux[15:0] = s_q.y;
      mag_seq_pkg::OFS_Z_RESULT:      rmux[15:0] = s_q.z;
      mag_seq_pkg::OFS_TEMP_RESULT:   rmux[7:0]  = s_q.temp;
      mag_seq_pkg::OFS_SECOND_STATUS: rmux[mag_seq_pkg::BIT_OVERFLOW] = s_q.ofl;
      mag_seq_pkg::OFS_MODE_CONTROL:  rmux[4:0]  = s_q.mode;
      mag_seq_pkg::OFS_CONTROL:       rmux[mag_seq_pkg::BIT_TEMP_ENABLE] = s_q.temp_en;
      mag_seq_pkg::OFS_SENS_ADJUST:   rmux[23:0] = s_q.sens;
      default:                        rmux = '0;
    endcase
  end

  always_comb
  begin
    s_d        = s_q;
    keep       = s_q;
    s_d.restart   = 1'b0;
    s_d.hreadyout = 1'b1;
    // Zero-wait slave: side effects of reads act at the address phase
    rd_fire   = HSEL && (HTRANS == mag_seq_pkg::HTRANS_NONSEQ) && HREADY && !HWRITE;
    wr_fire   = HSEL && (HTRANS == mag_seq_pkg::HTRANS_NONSEQ) && HREADY && HWRITE;
    addr      = (HADDR[31:8] == 24'h0) ? HADDR[7:0] : 8'hFF;
    rd_result = rd_fire && ((addr == mag_seq_pkg::OFS_X_RESULT) ||
                            (addr == mag_seq_pkg::OFS_Y_RESULT) ||
                            (addr == mag_seq_pkg::OFS_Z_RESULT) ||
                            (addr == mag_seq_pkg::OFS_TEMP_RESULT));
    rd_stat2  = rd_fire && (addr == mag_seq_pkg::OFS_SECOND_STATUS);
    mode_wr   = s_q.wr_pend && (s_q.wr_addr == mag_seq_pkg::OFS_MODE_CONTROL);
    ctl_wr    = s_q.wr_pend && (s_q.wr_addr == mag_seq_pkg::OFS_CONTROL);
    new_mode  = HWDATA[4:0];
    sync_rst  = (ctl_wr && HWDATA[mag_seq_pkg::BIT_SOFT_RESET]) || SUPPLY_OFF ||
                !EXTERNAL_RESET_N;
    meas_done  = (s_q.fsm == mag_seq_pkg::ST_MEASURE) &&
                 (s_q.meas_cnt == 32'(MEAS_CYCLES - 1));
    meas_start = 1'b0;
    store      = 1'b0;
    s_d.wr_pend = wr_fire;
    s_d.wr_addr = addr;
    if (rd_fire)
    begin
      s_d.rdata = rmux;
    end
    if (rd_result || rd_stat2)
    begin
      s_d.rdy_flag = 1'b0;
      s_d.ovr_flag = 1'b0;
    end
    if (rd_result)
    begin
      s_d.read_open = 1'b1;
    end
    if (rd_stat2)
    begin
      s_d.read_open = 1'b0;
    end
    if (ctl_wr)
    begin
      s_d.temp_en = HWDATA[mag_seq_pkg::BIT_TEMP_ENABLE];
    end
    unique case (s_q.fsm)
      mag_seq_pkg::ST_POWER_DOWN:
      begin
        // Data-ready is not touched on start, so a pending flag survives
        if (mode_wr && ((new_mode == mag_seq_pkg::MODE_SINGLE) ||
                        mag_seq_pkg::is_periodic(new_mode)))
        begin
          s_d.mode    = new_mode;
          meas_start  = 1'b1;
          s_d.restart = 1'b1;
        end
      end
      mag_seq_pkg::ST_MEASURE, mag_seq_pkg::ST_IDLE:
      begin
        if (mode_wr && (new_mode == mag_seq_pkg::MODE_POWER_DOWN))
        begin
          s_d.fsm  = mag_seq_pkg::ST_POWER_DOWN;
          s_d.mode = mag_seq_pkg::MODE_POWER_DOWN;
        end
        else if (mode_wr && mag_seq_pkg::is_periodic(new_mode) &&
                 mag_seq_pkg::is_periodic(s_q.mode))
        begin
          s_d.mode    = new_mode;
          meas_start  = 1'b1;
          s_d.restart = 1'b1;
        end
        else if (meas_done)
        begin
          store = 1'b1;
          if (s_q.mode == mag_seq_pkg::MODE_SINGLE)
          begin
            s_d.fsm  = mag_seq_pkg::ST_POWER_DOWN;
            s_d.mode = mag_seq_pkg::MODE_POWER_DOWN;
          end
          else
          begin
            s_d.fsm = mag_seq_pkg::ST_IDLE;
          end
        end
        else if ((s_q.fsm == mag_seq_pkg::ST_IDLE) && tick)
        begin
          meas_start = 1'b1;
        end
        // Other mode writes fall through untouched
      end
    endcase
    if (meas_start)
    begin
      s_d.fsm         = mag_seq_pkg::ST_MEASURE;
      s_d.meas_cnt    = '0;
      s_d.ofl         = 1'b0;
      s_d.temp_active = s_q.temp_en;
    end
    else if (s_q.fsm == mag_seq_pkg::ST_MEASURE)
    begin
      s_d.meas_cnt = s_q.meas_cnt + 32'h1;
    end
    // Results take new values only here, at measurement end; resets clear them
    if (store)
    begin
      if (s_d.read_open)
      begin
        s_d.ovr_flag = 1'b1;
      end
      else
      begin
        s_d.x   = SENSOR_X;
        s_d.y   = SENSOR_Y;
        s_d.z   = SENSOR_Z;
        s_d.ofl = SENSOR_OVERFLOW;
        if (s_q.temp_active)
        begin
          s_d.temp = SENSOR_TEMP;
        end
        if (s_q.rdy_flag && !(rd_result || rd_stat2))
        begin
          s_d.ovr_flag = 1'b1;
        end
        s_d.rdy_flag = 1'b1;
      end
    end
    if (!s_q.sens_loaded)
    begin
      s_d.sens        = {Z_SENSITIVITY_ADJUST, Y_SENSITIVITY_ADJUST, X_SENSITIVITY_ADJUST};
      s_d.sens_loaded = 1'b1;
    end
    if (sync_rst)
    begin
      keep            = s_d;
      s_d             = '0;
      s_d.sens        = keep.sens;
      s_d.sens_loaded = keep.sens_loaded;
      s_d.rdata       = keep.rdata;
      s_d.wr_pend     = keep.wr_pend;
      s_d.wr_addr     = keep.wr_addr;
      s_d.hreadyout   = 1'b1;
    end
    s_d.analog_on = (s_d.fsm == mag_seq_pkg::ST_MEASURE);
    // Gated here so the temperature pin leaves a flop directly
    s_d.temp_active = s_d.temp_active && s_d.analog_on;
  end

  // Power-on reset clears everything but HREADYOUT, fuse values reload afterwards
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s_q           <= '0;
      s_q.hreadyout <= mag_seq_pkg::RST_HREADYOUT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign HRDATA          = s_q.rdata;
  assign HREADYOUT       = s_q.hreadyout;
  assign HRESP           = 1'b0;
  assign DATA_READY      = s_q.rdy_flag;
  assign ANALOG_ENABLE   = s_q.analog_on;
  assign TEMP_ENABLE_OUT = s_q.temp_active;

  status_read_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (rd_fire && addr == mag_seq_pkg::OFS_FIRST_STATUS) |=> HRDATA[0] == $past(DATA_READY))
    else $error("first status read does not match data-ready pin");

  single_end_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (store && s_q.mode == mag_seq_pkg::MODE_SINGLE && !sync_rst) |=>
    (s_q.fsm == mag_seq_pkg::ST_POWER_DOWN && s_q.mode == 5'h00))
    else $error("single measurement did not return to power-down");

  ready_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (store && !s_q.read_open && !rd_result && !sync_rst) |=> DATA_READY)
    else $error("stored results did not raise data-ready");

  read_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
    ((rd_result || rd_stat2) && !store) |=> (!DATA_READY && !s_q.ovr_flag))
    else $error("result read did not clear data-ready and overrun");

  protect_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (store && s_q.read_open && !rd_stat2 && !sync_rst) |=>
    (s_q.x == $past(s_q.x) && s_q.ovr_flag))
    else $error("protected results were overwritten");

  overrun_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (store && DATA_READY && !s_q.read_open && !rd_result && !rd_stat2 && !sync_rst) |=>
    (DATA_READY && s_q.ovr_flag))
    else $error("skipped data set did not raise overrun");

  ovf_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (meas_start && !sync_rst) |=> (!s_q.ofl && s_q.fsm == mag_seq_pkg::ST_MEASURE))
    else $error("overflow not cleared at measurement start");

  mode_ignore_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (mode_wr && s_q.fsm != mag_seq_pkg::ST_POWER_DOWN && new_mode != 5'h00 &&
     !(mag_seq_pkg::is_periodic(new_mode) && mag_seq_pkg::is_periodic(s_q.mode)) &&
     !store && !sync_rst) |=> s_q.mode == $past(s_q.mode))
    else $error("mode write outside power-down was taken");

  soft_reset_a: assert property (@(posedge CLK) disable iff (!RST_B)
    sync_rst |=> (s_q.fsm == mag_seq_pkg::ST_POWER_DOWN && s_q.mode == 5'h00 &&
                  !DATA_READY && s_q.sens == $past(s_q.sens)))
    else $error("reset did not restore power-down or lost sensitivity values");

  idle_wake_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (s_q.fsm == mag_seq_pkg::ST_IDLE && tick && !mode_wr && !sync_rst) |=>
    ##[0:1] ANALOG_ENABLE)
    else $error("periodic idle did not wake on interval tick");

endmodule

// *** magnetometer_mode_sequencer_bench.sv ***
// Self-checking bench for the magnetometer mode sequencer.
// Assumes the host model as sole bus master and shortened interval counts.
module magnetometer_mode_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER[4] = '{400, 300, 200, 100};
  localparam logic [4:0] PMODE[4] = '{5'h02, 5'h04, 5'h06, 5'h08};
  localparam logic [7:0] A_STAT1 = mag_seq_pkg::OFS_FIRST_STATUS;
  localparam logic [7:0] A_STAT2 = mag_seq_pkg::OFS_SECOND_STATUS;
  localparam logic [7:0] A_X     = mag_seq_pkg::OFS_X_RESULT;
  localparam logic [7:0] A_Y     = mag_seq_pkg::OFS_Y_RESULT;
  localparam logic [7:0] A_Z     = mag_seq_pkg::OFS_Z_RESULT;
  localparam logic [7:0] A_TEMP  = mag_seq_pkg::OFS_TEMP_RESULT;
  localparam logic [7:0] A_MODE  = mag_seq_pkg::OFS_MODE_CONTROL;
  localparam logic [7:0] A_CTRL  = mag_seq_pkg::OFS_CONTROL;
  localparam logic [7:0] A_SENS  = mag_seq_pkg::OFS_SENS_ADJUST;
  localparam logic [31:0] ADJ    = 32'h003C5AA5;

  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        supply_off = 1'h0;
  logic        ext_rst_n = 1'h1;
  logic [15:0] sx = 16'h0;
  logic [15:0] sy = 16'h0;
  logic [15:0] sz = 16'h0;
  logic [7:0]  st = 8'h0;
  logic        sovf = 1'h0;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        data_ready;
  logic        analog_enable;
  logic        temp_en;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;

  initial forever #2 clk = ~clk;

  mag_host_model #(.WAIT_CYC(20)) host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  magnetometer_mode_sequencer #(.PERIOD1(PER[0]), .PERIOD2(PER[1]), .PERIOD3(PER[2]),
    .PERIOD4(PER[3]), .MEAS_CYCLES(8)) dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SUPPLY_OFF(supply_off), .EXTERNAL_RESET_N(ext_rst_n), .SENSOR_X(sx), .SENSOR_Y(sy),
    .SENSOR_Z(sz), .SENSOR_TEMP(st), .SENSOR_OVERFLOW(sovf), .X_SENSITIVITY_ADJUST(8'hA5),
    .Y_SENSITIVITY_ADJUST(8'h5A), .Z_SENSITIVITY_ADJUST(8'h3C), .DATA_READY(data_ready),
    .ANALOG_ENABLE(analog_enable), .TEMP_ENABLE_OUT(temp_en));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ceiling well above the roughly 6400 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask

  // Counts settled cycles until the analog enable shows v, at most 1000
  task automatic wait_ae(input logic v, inout int n);
    int k;
    for (k = 0; k < 1000 && analog_enable !== v; k++)
      tick();
    n += k;
  endtask

  task automatic sens(input logic [15:0] x, y, z, input logic [7:0] t, input logic o);
    sx <= x;
    sy <= y;
    sz <= z;
    st <= t;
    sovf <= o;
  endtask

  task automatic t_reset();
    rc(A_STAT1, 32'h0);
    rc(A_STAT2, 32'h0);
    rc(A_MODE, 32'h0);
    rc(A_CTRL, 32'h0);
    rc(8'h40, 32'h0);
    host.wr(A_STAT1, 32'hFFFFFFFF);
    host.wr(A_SENS, 32'h0);
    host.wr(A_CTRL, 32'h1);
    rc(A_STAT1, 32'h0);
    rc(A_SENS, ADJ);
    rc(A_CTRL, 32'h1);
    chk(hresp, 1'h0);
    $display("reset values test done");
  endtask

  task automatic t_single();
    int n;
    sens(16'h1234, 16'h5678, 16'h9ABC, 8'h5A, 1'h1);
    host.set_mode(mag_seq_pkg::MODE_SINGLE);
    tick();
    chk(analog_enable, 1'h1);
    chk(temp_en, 1'h1);
    wait_ae(1'h0, n);
    chk(data_ready, 1'h1);
    rc(A_STAT1, 32'h1);
    rc(A_MODE, 32'h0);
    rc(A_X, 32'h1234);
    tick();
    chk(data_ready, 1'h0);
    rc(A_Y, 32'h5678);
    rc(A_Z, 32'h9ABC);
    rc(A_TEMP, 32'h5A);
    rc(A_STAT2, 32'h1);
    $display("single measurement test done");
  endtask

  task automatic t_window();
    int n;
    logic [31:0] d;
    sens(16'h1111, 16'h2222, 16'h3333, 8'h44, 1'h0);
    host.set_mode(mag_seq_pkg::MODE_SINGLE);
    rc(A_STAT2, 32'h0);
    rc(A_X, 32'h1234);
    wait_ae(1'h0, n);
    host.rd(A_STAT1, d);
    chk(d[1], 1'h1);
    rc(A_X, 32'h1234);
    rc(A_Y, 32'h5678);
    rc(A_STAT2, 32'h0);
    $display("protected read test done");
  endtask

  task automatic t_periodic();
    int n;
    for (int i = 0; i < 4; i++)
    begin
      host.set_mode(PMODE[i]);
      wait_ae(1'h1, n);
      // First gap includes the counter restart; time a steady one instead
      wait_ae(1'h0, n);
      wait_ae(1'h1, n);
      n = 0;
      wait_ae(1'h0, n);
      wait_ae(1'h1, n);
      chk(n, PER[i]);
    end
    host.wr(A_MODE, 32'h1);
    rc(A_MODE, PMODE[3]);
    host.wr(A_MODE, PMODE[3]);
    rc(A_STAT1, 32'h3);
    host.wr(A_MODE, 32'h0);
    wait_ae(1'h0, n);
    n = 0;
    wait_ae(1'h1, n);
    chk(n, 1000);
    sens(16'hAAAA, 16'hBBBB, 16'hCCCC, 8'hDD, 1'h0);
    host.set_mode(mag_seq_pkg::MODE_SINGLE);
    tick();
    chk(data_ready, 1'h1);
    wait_ae(1'h0, n);
    rc(A_STAT1, 32'h3);
    rc(A_X, 32'hAAAA);
    rc(A_STAT1, 32'h0);
    rc(A_STAT2, 32'h0);
    $display("periodic test done");
  endtask

  task automatic t_resets();
    int n;
    for (int i = 0; i < 3; i++)
    begin
      host.set_mode(PMODE[3]);
      wait_ae(1'h1, n);
      wait_ae(1'h0, n);
      if (i == 0)
        host.wr(A_CTRL, 32'h2);
      else if (i == 1)
        supply_off <= 1'h1;
      else
        ext_rst_n <= 1'h0;
      tick();
      chk(data_ready, 1'h0);
      n = 0;
      wait_ae(1'h1, n);
      chk(n, 1000);
      supply_off <= 1'h0;
      ext_rst_n <= 1'h1;
      tick();
      rc(A_MODE, 32'h0);
      rc(A_CTRL, 32'h0);
      rc(A_SENS, ADJ);
    end
    $display("reset sources test done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    tick();
    t_reset();
    t_single();
    t_window();
    t_periodic();
    t_resets();
    end_sim();
  end
endmodule
